// file: hw/reconfig_tap.sv
// Test port controller with reconfiguration trigger and programming access
//
// Functional notes
// - Code 00 0110 0001 selects reconfiguration trigger
// - Request driven low while the trigger code is loaded and in Run-Test/Idle
// - Request released when leaving Run-Test/Idle
// - Programming instructions and data accepted via port
`timescale 1ns/1ns
module reconfig_tap (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Reconfiguration request, open-drain
  input wire logic reconfig_request_n_in,
  output logic reconfig_request_n_out,
  output logic reconfig_request_n_oe,
  // Programming access towards the configuration memory
  output logic [reconfig_pkg::IR_WIDTH-1:0] isp_instruction,
  output logic [reconfig_pkg::ISP_DATA_WIDTH-1:0] isp_data,
  output logic isp_data_valid
);
  import reconfig_pkg::*;

  // Synchronised port signals
  tap_link_if link ();
  // Test port state
  tap_state_t state_r;
  tap_state_t state_nxt;
  // Instruction shift and update registers
  logic [IR_WIDTH-1:0] ir_shift_r;
  logic [IR_WIDTH-1:0] ir_r;
  // Data shift register, also used as the one-bit bypass
  logic [ISP_DATA_WIDTH-1:0] dr_shift_r;
  // Request level, active while asserted
  logic request_r;
  // Decoded instruction classes
  logic is_trigger;
  logic is_isp;

  // Pin synchroniser
  tap_pin_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .link(link)
  );

  // Instruction decode
  assign is_trigger = (ir_r == RECONFIG_TRIGGER_INSTRUCTION);
  assign is_isp = (ir_r >= ISP_CODE_BASE) && (ir_r != IR_RESET_VALUE);

  // Next state of the test port controller
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TAP_RESET: state_nxt = link.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_nxt = link.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_nxt = link.tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: state_nxt = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_nxt = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_nxt = link.tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_nxt = link.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_nxt = link.tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: state_nxt = link.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_nxt = link.tms ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: state_nxt = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_nxt = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_nxt = link.tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_nxt = link.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_nxt = link.tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: state_nxt = link.tms ? TAP_SEL_DR : TAP_IDLE;
      default: state_nxt = TAP_RESET;
    endcase
  end

  // State advances on each rising test clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= TAP_RESET;
    end else if (link.tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // Instruction shift register: capture, then shift towards tdo
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_shift_r <= IR_CAPTURE_VALUE;
    end else if (link.tck_rise) begin
      if (state_r == TAP_CAPTURE_IR) begin
        ir_shift_r <= IR_CAPTURE_VALUE;
      end else if (state_r == TAP_SHIFT_IR) begin
        ir_shift_r <= {link.tdi, ir_shift_r[IR_WIDTH-1:1]};
      end
    end
  end

  // Instruction update on the falling edge in Update-IR
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_r <= IR_RESET_VALUE;
    end else if (state_r == TAP_RESET) begin
      ir_r <= IR_RESET_VALUE;
    end else if (link.tck_fall && state_r == TAP_UPDATE_IR) begin
      ir_r <= ir_shift_r;
    end
  end

  // Data register: programming word when selected, else bypass bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dr_shift_r <= '0;
    end else if (link.tck_rise) begin
      if (state_r == TAP_CAPTURE_DR) begin
        dr_shift_r <= '0;
      end else if (state_r == TAP_SHIFT_DR) begin
        if (is_isp) begin
          dr_shift_r <= {link.tdi, dr_shift_r[ISP_DATA_WIDTH-1:1]};
        end else begin
          dr_shift_r <= {{(ISP_DATA_WIDTH-1){1'b0}}, link.tdi};
        end
      end
    end
  end

  // Programming word handed to the memory on Update-DR, instruction copied every cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      isp_data <= '0;
      isp_data_valid <= 1'b0;
      isp_instruction <= IR_RESET_VALUE;
    end else begin
      isp_instruction <= ir_r;
      isp_data_valid <= 1'b0;
      if (link.tck_fall && state_r == TAP_UPDATE_DR && is_isp) begin
        isp_data <= dr_shift_r;
        isp_data_valid <= 1'b1;
      end
    end
  end

  // Serial output changes on the falling test clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (link.tck_fall) begin
      tdo_oe <= (state_r == TAP_SHIFT_IR) || (state_r == TAP_SHIFT_DR);
      if (state_r == TAP_SHIFT_IR) begin
        tdo <= ir_shift_r[0];
      end else begin
        tdo <= dr_shift_r[0];
      end
    end
  end

  // Request held while trigger is current and port is idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      request_r <= 1'b0;
    end else begin
      request_r <= is_trigger && (state_r == TAP_IDLE);
    end
  end

  // Open-drain drive: low while requested, otherwise released
  assign reconfig_request_n_out = 1'b0;
  assign reconfig_request_n_oe = request_r;
endmodule : reconfig_tap

// file: hw/reconfig_pkg.sv
// Package with instruction codes, widths and TAP state encoding
package reconfig_pkg;
  // Instruction register width
  localparam int unsigned IR_WIDTH = 10;
  // Reconfiguration trigger instruction code
  localparam logic [9:0] RECONFIG_TRIGGER_INSTRUCTION = 10'h061;
  // Instruction loaded on test logic reset (bypass)
  localparam logic [9:0] IR_RESET_VALUE = 10'h3ff;
  // Fixed capture pattern shifted out of the instruction register
  localparam logic [9:0] IR_CAPTURE_VALUE = 10'h001;
  // Width of the in-system programming data register
  localparam int unsigned ISP_DATA_WIDTH = 16;
  // Lowest code treated as an in-system programming instruction
  localparam logic [9:0] ISP_CODE_BASE = 10'h200;
  // Test access port states, Gray-like along the usual path
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h3,
    TAP_CAPTURE_DR = 4'h2,
    TAP_SHIFT_DR   = 4'h6,
    TAP_EXIT1_DR   = 4'h7,
    TAP_PAUSE_DR   = 4'h5,
    TAP_EXIT2_DR   = 4'h4,
    TAP_UPDATE_DR  = 4'hc,
    TAP_SEL_IR     = 4'hd,
    TAP_CAPTURE_IR = 4'hf,
    TAP_SHIFT_IR   = 4'he,
    TAP_EXIT1_IR   = 4'ha,
    TAP_PAUSE_IR   = 4'hb,
    TAP_EXIT2_IR   = 4'h9,
    TAP_UPDATE_IR  = 4'h8
  } tap_state_t;
endpackage : reconfig_pkg

// file: hw/tap_link_if.sv
// Interface carrying synchronised test port signals to the controller
`timescale 1ns/1ns
interface tap_link_if;
  // Synchronised test mode select level
  logic tms;
  // Synchronised test data in level
  logic tdi;
  // One-cycle pulse on each rising test clock edge
  logic tck_rise;
  // One-cycle pulse on each falling test clock edge
  logic tck_fall;
  // Producer side
  modport sync_side (output tms, output tdi, output tck_rise, output tck_fall);
  // Consumer side
  modport ctrl_side (input tms, input tdi, input tck_rise, input tck_fall);
endinterface : tap_link_if

// file: hw/tap_pin_sync.sv
// Two-stage synchronisers and test clock edge detection
`timescale 1ns/1ns
module tap_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  // Synchronised outputs
  tap_link_if.sync_side link
);
  // First and second stages for tck, tms, tdi
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  // Previous synchronised test clock level
  logic tck_prev_r;

  // Two flip-flops per pin before any logic reads it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= {tck, tms, tdi};
      sync_r <= meta_r;
    end
  end

  // Edge history of the synchronised test clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= sync_r[2];
    end
  end

  // Edge pulses and levels for the controller
  assign link.tck_rise = sync_r[2] & ~tck_prev_r;
  assign link.tck_fall = ~sync_r[2] & tck_prev_r;
  assign link.tms = sync_r[1];
  assign link.tdi = sync_r[0];
endmodule : tap_pin_sync

// file: verification/reconfig_tap_chk.sv
// Checker for the reconfiguration request and programming outputs
`timescale 1ns/1ns
module reconfig_tap_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched pins
  input wire logic tck,
  input wire logic tms,
  input wire logic reconfig_request_n_out,
  input wire logic reconfig_request_n_oe,
  input wire logic [reconfig_pkg::IR_WIDTH-1:0] isp_instruction,
  input wire logic isp_data_valid
);
  import reconfig_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Reset leaves bypass loaded and the line released
  reset_state_a: assert property (disable iff (1'b0) sys_rst |=> isp_instruction == IR_RESET_VALUE && !reconfig_request_n_oe) else $error("reset state wrong");
  // Only the trigger code may pull the line
  pull_needs_code_a: assert property (reconfig_request_n_oe |-> isp_instruction == RECONFIG_TRIGGER_INSTRUCTION) else $error("pull without trigger code");
  // Staying in idle keeps the pull
  pull_holds_a: assert property (reconfig_request_n_oe && $rose(tck) && !tms |=> reconfig_request_n_oe [*4]) else $error("pull dropped in idle");
  // Leaving idle releases within a few cycles
  pull_release_a: assert property (reconfig_request_n_oe && $rose(tck) && tms |-> ##[1:8] !reconfig_request_n_oe) else $error("pull not released");
  // Open-drain output only ever drives low
  drive_low_a: assert property (reconfig_request_n_out == 1'b0) else $error("request drives high");
  // Programming words appear as one-cycle pulses
  valid_pulse_a: assert property (isp_data_valid |=> !isp_data_valid) else $error("valid too long");
  // Programming words only under a programming code
  valid_code_a: assert property (isp_data_valid |-> isp_instruction >= ISP_CODE_BASE && isp_instruction != IR_RESET_VALUE) else $error("word under wrong code");
endmodule // reconfig_tap_chk

// file: verification/fpga_cfg_model.sv
// Model of the pulled-up configuration start input and its start count
`timescale 1ns/1ns
module fpga_cfg_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request pin as driven by the device
  input wire logic req_out,
  input wire logic req_oe,
  // Wire level and configuration starts
  output wire logic start_n,
  output logic [7:0] starts
);
  // Pull-up holds the wire high unless driven
  assign start_n = req_oe ? req_out : 1'b1;
  logic low_r; // Wire was low last cycle
  // A configuration starts only when the wire returns high
  always_ff @(posedge clk) begin
    low_r <= !start_n;
    if (sys_rst) begin
      starts <= 8'h00;
    end else if (low_r && start_n) begin
      starts <= starts + 8'h01;
    end
  end
endmodule // fpga_cfg_model

// file: verification/reconfig_tap_tb_top.sv
// Testbench driving the test port and checking trigger and programming
`timescale 1ns/1ns
module reconfig_tap_tb_top;
  import reconfig_pkg::*;
  logic clk = 0, sys_rst = 1, tck = 0, tms = 1, tdi = 0;
  wire req_line;
  logic req_oe, req_out, isp_valid, tdo_en;
  logic [IR_WIDTH-1:0] isp_instr;
  logic [ISP_DATA_WIDTH-1:0] isp_word;
  logic [7:0] starts;
  logic [31:0] seed = 32'hb79f08c9;
  logic [15:0] exp_q[$]; // Expected programming words
  int fails = 0, num_checks = 0;
  always #20 clk = ~clk;
  reconfig_tap DUT (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(),
    .tdo_oe(tdo_en), .reconfig_request_n_in(req_line), .reconfig_request_n_out(req_out),
    .reconfig_request_n_oe(req_oe), .isp_instruction(isp_instr), .isp_data(isp_word),
    .isp_data_valid(isp_valid));
  fpga_cfg_model fpga (.clk(clk), .sys_rst(sys_rst), .req_out(req_out), .req_oe(req_oe),
    .start_n(req_line), .starts(starts));
  // Xorshift step
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One test clock period, tms and tdi change at the falling edge
  task tbit(input logic m, input logic d);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task path(input logic [5:0] m, input int n);
    for (int i = 0; i < n; i++) tbit(m[i], 1'b0);
  endtask
  // Shift LSB first, leaving on the last bit
  task shift(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) tbit(i == n - 1, v[i]);
  endtask
  task ir(input logic [9:0] c);
    path(6'b000011, 4);
    shift({6'h00, c}, 10);
    path(6'b000001, 2);
  endtask
  // Bounded wait for the pull enable
  task wait_oe(input logic v);
    for (int k = 0; k < 30 && req_oe !== v; k++) @(posedge clk);
    if (req_oe !== v) begin
      fails++;
      complete_run();
    end
  endtask
  // Compare each programming word with the oldest note
  always @(posedge clk) begin
    if (isp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("isp_valid", 16'h1, 16'h0);
      else chk("isp_data", isp_word, exp_q.pop_front());
    end
  end
  initial begin
    logic [9:0] code;
    logic [15:0] d;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    chk("ir_reset", 16'(isp_instr), 16'(IR_RESET_VALUE));
    path(6'b0, 1);
    repeat (8) @(posedge clk);
    chk("oe_bypass", 16'(req_oe), 16'h0);
    $display("test reset done");
    ir(RECONFIG_TRIGGER_INSTRUCTION);
    chk("ir_trigger", 16'(isp_instr), 16'(RECONFIG_TRIGGER_INSTRUCTION));
    chk("tdo_off_idle", 16'(tdo_en), 16'h0);
    wait_oe(1'b1);
    chk("line_low", 16'(req_line), 16'h0);
    path(6'b0, 1);
    chk("oe_hold", 16'(req_oe), 16'h1);
    chk("starts_low", 16'(starts), 16'h0);
    path(6'b1, 1);
    wait_oe(1'b0);
    repeat (2) @(posedge clk);
    chk("line_high", 16'(req_line), 16'h1);
    chk("starts", 16'(starts), 16'h1);
    path(6'b011111, 6);
    chk("ir_tlr", 16'(isp_instr), 16'(IR_RESET_VALUE));
    $display("test trigger done");
    for (int k = 0; k < 4; k++) begin
      void'(rnd());
      code = (k == 3) ? 10'h055 : {1'b1, seed[8:1], 1'b0};
      d = seed[31:16];
      ir(code);
      chk("ir_loaded", 16'(isp_instr), 16'(code));
      if (k < 3) exp_q.push_back(d);
      path(6'b000001, 3);
      shift(d, 16);
      path(6'b000001, 2);
      chk("oe_isp", 16'(req_oe), 16'h0);
    end
    chk("words_left", 16'(exp_q.size()), 16'h0);
    $display("test programming done");
    complete_run();
  end
endmodule // reconfig_tap_tb_top
bind reconfig_tap reconfig_tap_chk u_chk (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
  .reconfig_request_n_out(reconfig_request_n_out), .reconfig_request_n_oe(reconfig_request_n_oe),
  .isp_instruction(isp_instruction), .isp_data_valid(isp_data_valid));
